//--- core/sssc_pkg.sv
package sssc_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] SSSC_CTRL_OFS   = 8'h00;
    localparam logic [7:0] SSSC_STATUS_OFS = 8'h04;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int          SSSC_LP_LSB    = 0;
    localparam int          SSSC_LP_W      = 6;
    localparam int          SSSC_SPEED_BIT = 8;
    localparam int          SSSC_ROLE_LSB  = 12;
    localparam int          SSSC_ROLE_W    = 4;
    localparam int          SSSC_BAUD_BIT  = 16;
    localparam logic [5:0]  SSSC_LP_RST    = 6'h00;
    localparam logic        SSSC_SPEED_RST = 1'b0;
    localparam logic [3:0]  SSSC_ROLE_RST  = 4'h0;
    localparam logic [3:0]  SSSC_ROLE_MPSL = 4'h3;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ      = 250;
    localparam int WAKE_MS      = 20;
    localparam int WAKE_CYCLES  = WAKE_MS * 1000 * CLK_MHZ;
    localparam int LAT_MIN_US   = 6000;
    localparam int LAT_MAX_US   = 2500000;

    typedef struct packed {
        logic       dimLamps;
        logic       radioAsleep;
        logic       highSpeed;
        logic       ctsOut;
    } sssc_pwr_t;

endpackage

//--- core/sssc_core.sv
module sssc_core
    import sssc_pkg::*;
#(
    parameter int WAKE_CNT = WAKE_CYCLES
)
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        clkEn,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Link status
    input  wire logic        slotTick,
    input  wire logic        linkUp,
    input  wire logic        txToMaster,
    // Serial port
    input  wire logic        rtsPin,
    output logic             ctsPin,
    // Power controls
    output logic             lampDim,
    output logic             radioSleep,
    output logic             cpuHighSpeed
);

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [5:0]  lpSetting_reg;
    logic        speedSel_reg;
    logic [3:0]  role_reg;
    logic        baud230_reg;
    logic        wbAccess;
    sssc_pwr_t   pwr;
    logic [31:0] ctrlWord;
    logic [31:0] statusWord;

    assign wbAccess = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_comb
    begin
        ctrlWord = 32'h0000_0000;
        ctrlWord[SSSC_LP_LSB +: SSSC_LP_W] = lpSetting_reg;
        ctrlWord[SSSC_SPEED_BIT] = speedSel_reg;
        ctrlWord[SSSC_ROLE_LSB +: SSSC_ROLE_W] = role_reg;
        ctrlWord[SSSC_BAUD_BIT] = baud230_reg;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            lpSetting_reg <= SSSC_LP_RST;
            speedSel_reg  <= SSSC_SPEED_RST;
            role_reg      <= SSSC_ROLE_RST;
            baud230_reg   <= 1'b0;
        end
        else if (clkEn && wbAccess && wb_we_i && wb_adr_i == SSSC_CTRL_OFS)
        begin
            if (wb_sel_i[0])
                lpSetting_reg <= wb_dat_i[SSSC_LP_LSB +: SSSC_LP_W];
            if (wb_sel_i[1])
            begin
                speedSel_reg <= wb_dat_i[SSSC_SPEED_BIT];
                role_reg     <= wb_dat_i[SSSC_ROLE_LSB +: SSSC_ROLE_W];
            end
            if (wb_sel_i[2])
                baud230_reg <= wb_dat_i[SSSC_BAUD_BIT];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            wb_ack_o <= wbAccess;
            if (wbAccess && !wb_we_i)
            begin
                case (wb_adr_i)
                    SSSC_CTRL_OFS:   wb_dat_o <= ctrlWord;
                    SSSC_STATUS_OFS: wb_dat_o <= statusWord;
                    default:         wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // RTS synchroniser
    // ----------------------------------------
    logic [2:0] rtsSync_reg;
    logic       rtsLevel_reg;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rtsSync_reg  <= 3'h0;
            rtsLevel_reg <= 1'b0;
        end
        else if (clkEn)
        begin
            rtsSync_reg <= {rtsSync_reg[1:0], rtsPin};
            // First stage is never looked at; only agreed stages count
            if (rtsSync_reg[1] == rtsSync_reg[2])
                rtsLevel_reg <= rtsSync_reg[2];
        end
    end

    // ----------------------------------------
    // Wake state machine
    // ----------------------------------------
    typedef enum logic [2:0] {
        SSSC_ST_SAVE  = 3'b001,
        SSSC_ST_WAKE  = 3'b010,
        SSSC_ST_AWAKE = 3'b100
    } sssc_wake_t;

    sssc_wake_t  wake_reg;
    logic [31:0] wakeCnt_reg;
    logic        saving;

    // Saving only for a linked multipoint slave with a nonzero setting
    assign saving = (role_reg == SSSC_ROLE_MPSL) && linkUp
                  && (lpSetting_reg != SSSC_LP_RST);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            wake_reg    <= SSSC_ST_SAVE;
            wakeCnt_reg <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            case (wake_reg)
                SSSC_ST_SAVE:
                begin
                    wakeCnt_reg <= 32'h0000_0000;
                    if (rtsLevel_reg)
                        wake_reg <= saving ? SSSC_ST_WAKE : SSSC_ST_AWAKE;
                end
                SSSC_ST_WAKE:
                begin
                    // Radio is powered now; CTS waits for the wake interval
                    wakeCnt_reg <= wakeCnt_reg + 32'h0000_0001;
                    if (!rtsLevel_reg)
                        wake_reg <= SSSC_ST_SAVE;
                    else if (wakeCnt_reg >= 32'(WAKE_CNT - 1))
                        wake_reg <= SSSC_ST_AWAKE;
                end
                SSSC_ST_AWAKE:
                begin
                    if (!rtsLevel_reg)
                        wake_reg <= SSSC_ST_SAVE;
                end
                default:
                    wake_reg <= SSSC_ST_SAVE;
            endcase
        end
    end

    // ----------------------------------------
    // Slot counter
    // ----------------------------------------
    logic [5:0] slotCnt_reg;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            slotCnt_reg <= 6'h00;
        else if (clkEn && slotTick)
        begin
            if (slotCnt_reg + 6'h01 >= lpSetting_reg)
                slotCnt_reg <= 6'h00;
            else
                slotCnt_reg <= slotCnt_reg + 6'h01;
        end
    end

    // ----------------------------------------
    // Power outputs
    // ----------------------------------------
    logic rtsHold;

    assign rtsHold = (wake_reg != SSSC_ST_SAVE);

    always_comb
    begin
        pwr.dimLamps    = saving && !rtsHold;
        // Slot zero stays awake; settings 0 and 1 never sleep
        pwr.radioAsleep = saving && !rtsHold && !txToMaster
                        && (lpSetting_reg > 6'h01)
                        && (slotCnt_reg != 6'h00);
        // 230 Kbaud overrides a low speed request
        pwr.highSpeed   = speedSel_reg || baud230_reg;
        pwr.ctsOut      = (wake_reg == SSSC_ST_AWAKE);
    end

    // Link latency from sleeping is bounded by slot period, not by logic here
    assign statusWord = {26'h0, pwr, rtsLevel_reg, saving};

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            lampDim      <= 1'b0;
            radioSleep   <= 1'b0;
            cpuHighSpeed <= 1'b0;
            ctsPin       <= 1'b0;
        end
        else if (clkEn)
        begin
            lampDim      <= pwr.dimLamps;
            radioSleep   <= pwr.radioAsleep;
            cpuHighSpeed <= pwr.highSpeed;
            ctsPin       <= pwr.ctsOut;
        end
    end

endmodule

//--- tb/sssc_sva.sv
module sssc_sva
(
    // Watched ports
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic linkUp,
    input wire logic txToMaster,
    input wire logic rtsPin,
    input wire logic ctsPin,
    input wire logic lampDim,
    input wire logic radioSleep
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o)
        else $error("no ack");
    a_rts_awake: assert property (rtsPin [*7] |-> !radioSleep && !lampDim)
        else $error("saving while rts high");
    a_tx_awake: assert property (clkEn && txToMaster |=> !radioSleep)
        else $error("asleep while sending");
    a_link_off: assert property (clkEn && !linkUp |=> !radioSleep && !lampDim)
        else $error("saving without link");
    a_sleep_dims: assert property (radioSleep |-> lampDim)
        else $error("asleep but lamps bright");
    a_cts_drop: assert property (!rtsPin [*7] |-> !ctsPin)
        else $error("cts stuck high");
    a_cts_cause: assert property ($rose(ctsPin) |-> $past(rtsPin, 3))
        else $error("cts without rts");
endmodule

bind sssc_core sssc_sva u_sva (
    .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .linkUp(linkUp), .txToMaster(txToMaster),
    .rtsPin(rtsPin), .ctsPin(ctsPin), .lampDim(lampDim), .radioSleep(radioSleep));

//--- tb/sssc_term.sv
module sssc_term
(
    // Bench side
    input  wire logic sys_clk,
    input  wire logic wantTx,
    output logic      sendOk,
    output int        waitCyc,
    // Serial lines
    input  wire logic ctsPin,
    output logic      rtsPin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Held for the whole exchange, a short pulse may never wake the unit
    always_ff @(posedge sys_clk)
        rtsPin <= wantTx;
    always_ff @(posedge sys_clk)
        sendOk <= rtsPin & ctsPin;
    always_ff @(posedge sys_clk)
        waitCyc <= !rtsPin ? 0 : waitCyc + int'(!ctsPin);
endmodule

//--- tb/slave_slot_sleep_control_bench.sv
module slave_slot_sleep_control_bench
    import sssc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [19:0] ctrl;
        logic        link;
        logic        tx;
        logic [5:0]  ticks;
        logic        dim;
        logic [5:0]  sleeps;
        logic        hi;
    } sssc_row_t;
    localparam int WAKE = 20;
    logic        sys_clk, rst_b, wbCyc, wbStb, wbWe, wbAck, slotTick, linkUp, txToMaster;
    logic        wantTx, rtsPin, ctsPin, lampDim, radioSleep, cpuHighSpeed, sendOk;
    logic        clkEn;
    logic [7:0]  wbAdr;
    logic [31:0] wbDatW, wbDatR, rd;
    int          mismatches, totalChecks, waitCyc, cnt;
    sssc_row_t   rows [9];

    sssc_core #(.WAKE_CNT(WAKE)) DUT (
        .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(4'hF),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .slotTick(slotTick), .linkUp(linkUp),
        .txToMaster(txToMaster), .rtsPin(rtsPin), .ctsPin(ctsPin), .lampDim(lampDim),
        .radioSleep(radioSleep), .cpuHighSpeed(cpuHighSpeed));
    sssc_term u_term (.sys_clk(sys_clk), .wantTx(wantTx), .sendOk(sendOk),
        .waitCyc(waitCyc), .ctsPin(ctsPin), .rtsPin(rtsPin));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        totalChecks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wbx(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDatW <= d;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wbAck !== 1'b1 && n < 99);
        if (n >= 99)
            mismatches++;
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic tick(input logic [5:0] n);
        cnt = 0;
        repeat (n)
        begin
            slotTick <= 1'b1;
            @(posedge sys_clk);
            slotTick <= 1'b0;
            repeat (2) @(posedge sys_clk);
            cnt += int'(radioSleep === 1'b1);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d bad %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial
    begin
        #40000;
        mismatches++;
        finish_test;
    end

    initial
    begin
        {rst_b, wbCyc, wbStb, wbWe, slotTick, linkUp, txToMaster, wantTx} = 8'h00;
        {wbAdr, wbDatW} = 40'h0;
        clkEn = 1'b1;
        rows = '{'{20'h03000, 1'h1, 1'h0, 6'h06, 1'h0, 6'h00, 1'h0},
                 '{20'h03101, 1'h1, 1'h0, 6'h06, 1'h1, 6'h00, 1'h1},
                 '{20'h13002, 1'h1, 1'h0, 6'h06, 1'h1, 6'h03, 1'h1},
                 '{20'h03003, 1'h1, 1'h0, 6'h06, 1'h1, 6'h04, 1'h0},
                 '{20'h03006, 1'h1, 1'h0, 6'h06, 1'h1, 6'h05, 1'h0},
                 '{20'h03002, 1'h0, 1'h0, 6'h06, 1'h0, 6'h00, 1'h0},
                 '{20'h02002, 1'h1, 1'h0, 6'h06, 1'h0, 6'h00, 1'h0},
                 '{20'h03002, 1'h1, 1'h1, 6'h06, 1'h1, 6'h00, 1'h0},
                 '{20'h0303F, 1'h1, 1'h0, 6'h3F, 1'h1, 6'h3E, 1'h0}};
        repeat (5) @(posedge sys_clk);
        chk({28'h0, ctsPin, lampDim, radioSleep, cpuHighSpeed}, 32'h0);
        rst_b <= 1'b1;
        wbx(SSSC_CTRL_OFS, 1'b0, 32'h0);
        chk(rd, 32'h0);
        wbx(8'h08, 1'b1, 32'hFFFFFFFF);
        wbx(8'h08, 1'b0, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 9; i++)
        begin
            wbx(SSSC_CTRL_OFS, 1'b1, 32'(rows[i].ctrl));
            linkUp <= rows[i].link;
            txToMaster <= rows[i].tx;
            tick(rows[i].ticks);
            chk(32'(lampDim), 32'(rows[i].dim));
            chk(32'(cnt), 32'(rows[i].sleeps));
            chk(32'(cpuHighSpeed), 32'(rows[i].hi));
            $display("row %0d done", i);
        end
        wbx(SSSC_CTRL_OFS, 1'b1, 32'h00003002);
        wantTx <= 1'b1;
        repeat (99) if (sendOk !== 1'b1) @(posedge sys_clk);
        chk(32'(waitCyc >= WAKE && waitCyc <= WAKE + 10), 32'h1);
        tick(6'h06);
        chk(32'(cnt) + 32'(lampDim), 32'h0);
        wantTx <= 1'b0;
        // Let the released RTS pass the synchroniser before counting slots
        repeat (8) @(posedge sys_clk);
        tick(6'h06);
        chk(32'(cnt), 32'h3);
        $display("wake test done");
        clkEn <= 1'b0;
        tick(6'h05);
        chk(32'(cnt), 32'h0);
        clkEn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(32'(radioSleep), 32'h0);
        $display("freeze test done");
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        wbx(SSSC_CTRL_OFS, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk({28'h0, ctsPin, lampDim, radioSleep, cpuHighSpeed}, 32'h0);
        $display("reset test done");
        finish_test;
    end
endmodule
